//--- src/icsc_cfg.svh
// icsc_cfg.svh: offsets, bit positions and reset values of the bus control/status core
// assumes: included by bare name from the core module
`ifndef ICSC_CFG_SVH
`define ICSC_CFG_SVH
// ************************************************
// register offsets (byte addresses)
// ************************************************
`define ICSC_OFF_CR 5'h00
`define ICSC_OFF_SR1 5'h04
`define ICSC_OFF_SR2 5'h08
`define ICSC_OFF_DR 5'h18
// ************************************************
// control bit positions
// ************************************************
`define ICSC_CR_PE 5
`define ICSC_CR_GENERAL_CALL_ENABLE 4
`define ICSC_CR_START 3
`define ICSC_CR_ACK 2
`define ICSC_CR_STOP 1
`define ICSC_CR_ITE 0
// ************************************************
// values
// ************************************************
`define ICSC_RST_BYTE 8'h00
`define ICSC_RSV2 2'h0
`define ICSC_GC_ADDR 8'h00
`define ICSC_IGN_ADDR 8'h01
`endif

//--- src/icsc_core.sv
// icsc_core.sv: control and status logic of a two-wire bus interface
// assumes: a bit engine on clk_i shifts bytes and reports events as one-cycle pulses;
// scl_i/sda_i are the raw bus levels, sampled here by clk_i
//
// How it works
// - disable clears all but stop and busy, releases lines
// - general call acks 00h, never 01h
// - start request: repeated or when bus free
// - ack enable drives acknowledge after bytes
// - master stop after byte, cleared when sent
// - slave stop releases lines, software clears it
// - interrupt enable gates every request
// - clock held low while hold flags set, unless a slave stop releases lines
// - two interrupt lines: bus and data
// - event flag is any pending event
// - header flag: set by header, cleared sequenced
// - direction flag valid with byte finished
// - busy tracks start/stop even when disabled
// - byte finished cleared by status then data
// - transmit byte finished after ack pulse
// - receive byte finished after our ack pulse
// - address matched set on own or general
// - master flag set by start, cleared on loss
// - start sent cleared by status then write
// - control reserved bits read zero
`timescale 1ns/1ps
`include "icsc_cfg.svh"
module icsc_core #(
  parameter int AW = 5
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // register port
  input wire logic [AW-1:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // bus pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic scl_oe_o,
  output logic sda_o,
  output logic sda_oe_o,
  // bit engine requests
  output logic eng_start_o,
  output logic eng_stop_o,
  output logic eng_ack_en_o,
  output logic eng_addr_ack_o,
  output logic eng_tx_load_o,
  output logic [7:0] eng_tx_data_o,
  // bit engine events
  input wire logic eng_start_done_i,
  input wire logic eng_stop_done_i,
  input wire logic eng_byte_done_i,
  input wire logic eng_byte_tx_i,
  input wire logic eng_addr_valid_i,
  input wire logic [7:0] eng_rx_addr_i,
  input wire logic eng_own_match_i,
  input wire logic eng_header_sent_i,
  input wire logic eng_end_addr_i,
  input wire logic eng_ack_fail_i,
  input wire logic eng_arb_lost_i,
  input wire logic eng_bus_err_i,
  input wire logic [7:0] eng_rx_data_i,
  input wire logic eng_scl_low_i,
  input wire logic eng_sda_low_i,
  // interrupt lines
  output logic irq_bus_o,
  output logic irq_data_o
);
  // ************************************************
  // register access decode
  // ************************************************
  logic wr_cr, rd_sr1, rd_sr2, rd_dr, wr_dr;
  assign wr_cr = wr_i && (addr_i == `ICSC_OFF_CR);
  assign wr_dr = wr_i && (addr_i == `ICSC_OFF_DR);
  assign rd_sr1 = rd_i && (addr_i == `ICSC_OFF_SR1);
  assign rd_sr2 = rd_i && (addr_i == `ICSC_OFF_SR2);
  assign rd_dr = rd_i && (addr_i == `ICSC_OFF_DR);

  // ************************************************
  // control register
  // ************************************************
  logic pe_r, general_call_enable_r, start_r, ack_r, stop_r, ite_r;
  icsc_pkg::icsc_cmd_t cmd_r;
  logic master_r;

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      pe_r <= 1'b0;
      general_call_enable_r <= 1'b0;
      start_r <= 1'b0;
      ack_r <= 1'b0;
      ite_r <= 1'b0;
    end else if (wr_cr && pe_r) begin
      pe_r <= wdata_i[`ICSC_CR_PE];
      general_call_enable_r <= wdata_i[`ICSC_CR_GENERAL_CALL_ENABLE] && wdata_i[`ICSC_CR_PE];
      start_r <= wdata_i[`ICSC_CR_START] && wdata_i[`ICSC_CR_PE];
      ack_r <= wdata_i[`ICSC_CR_ACK] && wdata_i[`ICSC_CR_PE];
      ite_r <= wdata_i[`ICSC_CR_ITE] && wdata_i[`ICSC_CR_PE];
    end else if (wr_cr) begin
      // first enabling write wakes the interface only
      pe_r <= wdata_i[`ICSC_CR_PE];
    end else if (!pe_r) begin
      general_call_enable_r <= 1'b0;
      start_r <= 1'b0;
      ack_r <= 1'b0;
      ite_r <= 1'b0;
    end else if (eng_start_done_i) begin
      start_r <= 1'b0;
    end
  end

  // stop survives disable; master stop cleared when sent, slave stop only by software
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      stop_r <= 1'b0;
    end else if (wr_cr && pe_r) begin
      stop_r <= wdata_i[`ICSC_CR_STOP];
    end else if (eng_stop_done_i && (cmd_r == icsc_pkg::CMD_STOP)) begin
      // the stop on the bus already dropped master mode, so key on the command, not on master_r
      stop_r <= 1'b0;
    end
  end

  // ************************************************
  // pin sampling and start/stop detection
  // ************************************************
  logic scl_s1_r, scl_s2_r, sda_s1_r, sda_s2_r, sda_d_r;
  logic start_det, stop_det, busy_r;
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      scl_s1_r <= 1'b1;
      scl_s2_r <= 1'b1;
      sda_s1_r <= 1'b1;
      sda_s2_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_s1_r <= scl_i;
      scl_s2_r <= scl_s1_r;
      sda_s1_r <= sda_i;
      sda_s2_r <= sda_s1_r;
      sda_d_r <= sda_s2_r;
    end
  end
  assign start_det = scl_s2_r && sda_d_r && !sda_s2_r;
  assign stop_det = scl_s2_r && !sda_d_r && sda_s2_r;

  // busy ignores enable on purpose so a late enable still sees a running bus
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      busy_r <= 1'b0;
    end else if (start_det) begin
      busy_r <= 1'b1;
    end else if (stop_det) begin
      busy_r <= 1'b0;
    end
  end

  // ************************************************
  // command sequencer toward the bit engine
  // ************************************************
  always_ff @(posedge clk_i) begin
    if (!rstn_i || !pe_r) begin
      cmd_r <= icsc_pkg::CMD_IDLE;
    end else begin
      case (cmd_r)
        icsc_pkg::CMD_IDLE: begin
          if (start_r && (master_r || !busy_r)) begin
            cmd_r <= icsc_pkg::CMD_START;
          end else if (stop_r && master_r) begin
            cmd_r <= icsc_pkg::CMD_STOP;
          end
        end
        icsc_pkg::CMD_START: begin
          if (eng_start_done_i) begin
            cmd_r <= icsc_pkg::CMD_IDLE;
          end
        end
        icsc_pkg::CMD_STOP: begin
          if (eng_stop_done_i) begin
            cmd_r <= icsc_pkg::CMD_IDLE;
          end
        end
        default: begin
          cmd_r <= icsc_pkg::CMD_IDLE;
        end
      endcase
    end
  end
  assign eng_start_o = cmd_r[1];
  assign eng_stop_o = cmd_r[2];

  always_ff @(posedge clk_i) begin
    if (!rstn_i || !pe_r) begin
      master_r <= 1'b0;
    end else if (cmd_r == icsc_pkg::CMD_START) begin
      master_r <= 1'b1;
    end else if (stop_det || eng_arb_lost_i) begin
      master_r <= 1'b0;
    end
  end

  // ************************************************
  // access sequence memory
  // ************************************************
  logic sr1_seen_r, sr2_seen_r;
  always_ff @(posedge clk_i) begin
    if (!rstn_i || !pe_r) begin
      sr1_seen_r <= 1'b0;
      sr2_seen_r <= 1'b0;
    end else begin
      if (rd_sr1) begin
        sr1_seen_r <= 1'b1;
      end else if (rd_dr || wr_dr) begin
        sr1_seen_r <= 1'b0;
      end
      if (rd_sr2) begin
        sr2_seen_r <= 1'b1;
      end else if (wr_dr || wr_cr) begin
        sr2_seen_r <= 1'b0;
      end
    end
  end

  // ************************************************
  // status flags: a set in the clearing cycle wins
  // ************************************************
  logic btf_r, tra_r, addr_matched_flag_r, sb_r, header_sent_flag_r;
  logic end_of_address_flag_r, af_r, stop_detected_flag_r, arbitration_lost_flag_r, bus_error_flag_r, gcal_r;
  logic gc_hit, addr_hit, event_flag;
  assign gc_hit = general_call_enable_r && (eng_rx_addr_i == `ICSC_GC_ADDR);
  assign addr_hit = eng_addr_valid_i && (eng_rx_addr_i != `ICSC_IGN_ADDR) && (eng_own_match_i || gc_hit);

  always_ff @(posedge clk_i) begin
    if (!rstn_i || !pe_r) begin
      btf_r <= 1'b0;
      tra_r <= 1'b0;
    end else if (eng_byte_done_i) begin
      btf_r <= 1'b1;
      tra_r <= eng_byte_tx_i;
    end else begin
      if (sr1_seen_r && (rd_dr || wr_dr) || wr_dr && tra_r) begin
        btf_r <= 1'b0;
        tra_r <= 1'b0;
      end else if (stop_det || eng_arb_lost_i) begin
        tra_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i || !pe_r) begin
      addr_matched_flag_r <= 1'b0;
      gcal_r <= 1'b0;
    end else begin
      if (addr_hit) begin
        addr_matched_flag_r <= 1'b1;
      end else if (rd_sr1) begin
        addr_matched_flag_r <= 1'b0;
      end
      if (eng_addr_valid_i && gc_hit) begin
        gcal_r <= 1'b1;
      end else if (stop_det) begin
        gcal_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i || !pe_r) begin
      sb_r <= 1'b0;
      header_sent_flag_r <= 1'b0;
      end_of_address_flag_r <= 1'b0;
    end else begin
      if (eng_start_done_i) begin
        sb_r <= 1'b1;
      end else if (sr1_seen_r && wr_dr) begin
        sb_r <= 1'b0;
      end
      if (eng_header_sent_i) begin
        header_sent_flag_r <= 1'b1;
      end else if (sr2_seen_r && wr_dr) begin
        header_sent_flag_r <= 1'b0;
      end
      if (eng_end_addr_i) begin
        end_of_address_flag_r <= 1'b1;
      end else if (sr2_seen_r && wr_cr) begin
        end_of_address_flag_r <= 1'b0;
      end
    end
  end

  // error flags clear on a second-status read
  always_ff @(posedge clk_i) begin
    if (!rstn_i || !pe_r) begin
      af_r <= 1'b0;
      stop_detected_flag_r <= 1'b0;
      arbitration_lost_flag_r <= 1'b0;
      bus_error_flag_r <= 1'b0;
    end else begin
      af_r <= eng_ack_fail_i || (af_r && !rd_sr2);
      stop_detected_flag_r <= stop_det || (stop_detected_flag_r && !rd_sr2);
      arbitration_lost_flag_r <= eng_arb_lost_i || (arbitration_lost_flag_r && !rd_sr2);
      bus_error_flag_r <= eng_bus_err_i || (bus_error_flag_r && !rd_sr2);
    end
  end

  assign event_flag = btf_r || addr_matched_flag_r || sb_r || af_r || stop_detected_flag_r || arbitration_lost_flag_r || bus_error_flag_r || header_sent_flag_r || end_of_address_flag_r;

  // ************************************************
  // line control, engine handshakes, interrupts
  // ************************************************
  logic hold, release_r, out_low_r, ack_en_r, addr_ack_r, tx_load_r;
  logic [7:0] tx_data_r;
  logic scl_oe_r, sda_oe_r, irq_bus_r, irq_data_r;
  assign hold = header_sent_flag_r || sb_r || btf_r || addr_matched_flag_r || end_of_address_flag_r;

  always_ff @(posedge clk_i) begin
    if (!rstn_i || !pe_r) begin
      release_r <= 1'b0;
    end else begin
      // a slave stop keeps the lines free until software drops it
      release_r <= stop_r && !master_r && (btf_r || release_r);
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      scl_oe_r <= 1'b0;
      sda_oe_r <= 1'b0;
      out_low_r <= 1'b0;
    end else begin
      scl_oe_r <= pe_r && !release_r && (hold || eng_scl_low_i);
      sda_oe_r <= pe_r && !release_r && eng_sda_low_i;
      out_low_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      ack_en_r <= 1'b0;
      addr_ack_r <= 1'b0;
      tx_load_r <= 1'b0;
      tx_data_r <= `ICSC_RST_BYTE;
    end else begin
      ack_en_r <= pe_r && ack_r;
      addr_ack_r <= pe_r && ack_r && addr_hit;
      tx_load_r <= wr_dr && pe_r;
      if (wr_dr) begin
        tx_data_r <= wdata_i;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      irq_bus_r <= 1'b0;
      irq_data_r <= 1'b0;
    end else begin
      irq_bus_r <= ite_r && (sb_r || af_r || stop_detected_flag_r || arbitration_lost_flag_r || bus_error_flag_r || header_sent_flag_r || end_of_address_flag_r);
      irq_data_r <= ite_r && (btf_r || addr_matched_flag_r);
    end
  end

  // ************************************************
  // read data, one cycle after the strobe
  // ************************************************
  logic [7:0] rdata_r;
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      rdata_r <= `ICSC_RST_BYTE;
    end else if (rd_i) begin
      case (addr_i)
        `ICSC_OFF_CR: rdata_r <= {`ICSC_RSV2, pe_r, general_call_enable_r, start_r, ack_r, stop_r, ite_r};
        `ICSC_OFF_SR1: rdata_r <= {event_flag, header_sent_flag_r, tra_r && btf_r, busy_r, btf_r, addr_matched_flag_r, master_r, sb_r};
        `ICSC_OFF_SR2: rdata_r <= {`ICSC_RSV2, end_of_address_flag_r, af_r, stop_detected_flag_r, arbitration_lost_flag_r, bus_error_flag_r, gcal_r};
        `ICSC_OFF_DR: rdata_r <= eng_rx_data_i;
        default: rdata_r <= `ICSC_RST_BYTE;
      endcase
    end else begin
      rdata_r <= `ICSC_RST_BYTE;
    end
  end

  assign rdata_o = rdata_r;
  assign scl_o = out_low_r;
  assign sda_o = out_low_r;
  assign scl_oe_o = scl_oe_r;
  assign sda_oe_o = sda_oe_r;
  assign eng_ack_en_o = ack_en_r;
  assign eng_addr_ack_o = addr_ack_r;
  assign eng_tx_load_o = tx_load_r;
  assign eng_tx_data_o = tx_data_r;
  assign irq_bus_o = irq_bus_r;
  assign irq_data_o = irq_data_r;

  // ************************************************
  // assertions
  // ************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  property p_off_release;
    !pe_r |=> !scl_oe_o && !sda_oe_o && !general_call_enable_r && !ite_r && !btf_r && !master_r;
  endproperty
  a_off_release: assert property (p_off_release) else $error("disabled core still active");

  property p_first_write;
    wr_cr && !pe_r |=> !general_call_enable_r && !start_r && !ack_r && !ite_r;
  endproperty
  a_first_write: assert property (p_first_write) else $error("first write set more than enable");

  property p_ignore_01;
    eng_addr_valid_i && eng_rx_addr_i == `ICSC_IGN_ADDR |=> !eng_addr_ack_o;
  endproperty
  a_ignore_01: assert property (p_ignore_01) else $error("address 01h acknowledged");

  property p_start_clear;
    pe_r && eng_start_done_i && !wr_cr |=> !start_r && sb_r;
  endproperty
  a_start_clear: assert property (p_start_clear) else $error("start not cleared when sent");

  property p_irq_gate;
    !ite_r |=> !irq_bus_o && !irq_data_o;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("interrupt while disabled");

  property p_hold_scl;
    pe_r && !release_r && (header_sent_flag_r || sb_r || btf_r || addr_matched_flag_r || end_of_address_flag_r) |=> scl_oe_o;
  endproperty
  a_hold_scl: assert property (p_hold_scl) else $error("clock not held");

  property p_evf;
    pe_r && eng_byte_done_i ##1 pe_r |-> event_flag && btf_r;
  endproperty
  a_evf: assert property (p_evf) else $error("event flag missing");

  property p_busy;
    stop_det && !start_det |=> !busy_r;
  endproperty
  a_busy: assert property (p_busy) else $error("busy not cleared by stop");

  property p_btf_clear;
    pe_r && btf_r && sr1_seen_r && rd_dr && !eng_byte_done_i |=> !btf_r;
  endproperty
  a_btf_clear: assert property (p_btf_clear) else $error("byte finished not cleared");

  property p_arbitration_lost_flag_slave;
    eng_arb_lost_i |=> !master_r ##1 irq_bus_o == ite_r;
  endproperty
  a_arbitration_lost_flag_slave: assert property (p_arbitration_lost_flag_slave) else $error("master kept after loss");

  property p_cr_rsv;
    rd_i && addr_i == `ICSC_OFF_CR |=> rdata_o[7:6] == `ICSC_RSV2;
  endproperty
  a_cr_rsv: assert property (p_cr_rsv) else $error("reserved control bits set");

  c_start: cover property (eng_start_done_i ##1 sb_r ##[1:20] tx_load_r);
  c_rx_byte: cover property (btf_r && !tra_r ##[1:20] !btf_r);
  c_gc: cover property (eng_addr_valid_i && gc_hit ##1 eng_addr_ack_o);
  c_release: cover property (release_r ##1 !scl_oe_o);
endmodule : icsc_core

//--- src/icsc_pkg.sv
// icsc_pkg.sv: types of the bus control/status core
// assumes: used by scoped name only, never imported
package icsc_pkg;
  // one-hot command state toward the bit engine
  typedef enum logic [2:0] {
    CMD_IDLE = 3'h1,
    CMD_START = 3'h2,
    CMD_STOP = 3'h4
  } icsc_cmd_t;
endpackage : icsc_pkg

//--- verif/icsc_core_bench.sv
// icsc_core_bench.sv: self-checking bench of the control/status core
// assumes: far model answers the engine start/stop requests and owns the bus lines
`timescale 1ns/1ps
module icsc_core_bench;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [4:0] addr = 5'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [6:0] ev = 7'h00;
  logic [7:0] rxa = 8'h00;
  logic [7:0] rxd = 8'h00;
  logic [1:0] ext = 2'b00;
  logic btx = 1'b0, own = 1'b0, scl_low = 1'b0, sda_low = 1'b0, slow = 1'b0;
  logic [7:0] rdata, tx_data;
  logic scl, sda, scl_oe, sda_oe, start_o, stop_o, ack_en, addr_ack, tx_load;
  logic sdone, pdone, irq_bus, irq_data, scl_o, sda_o;
  logic [31:0] seed = 32'h00005958;
  int fails = 0;
  int n_tests = 0;
  always #25 clk = !clk;
  // ************************************************
  // design and far side
  // ************************************************
  icsc_core u_icsc_core (
    .clk_i(clk), .rstn_i(rstn), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
    .rdata_o(rdata), .scl_i(scl), .sda_i(sda), .scl_o(scl_o), .scl_oe_o(scl_oe), .sda_o(sda_o),
    .sda_oe_o(sda_oe), .eng_start_o(start_o), .eng_stop_o(stop_o), .eng_ack_en_o(ack_en),
    .eng_addr_ack_o(addr_ack), .eng_tx_load_o(tx_load), .eng_tx_data_o(tx_data),
    .eng_start_done_i(sdone), .eng_stop_done_i(pdone), .eng_byte_done_i(ev[0]), .eng_byte_tx_i(btx),
    .eng_addr_valid_i(ev[1]), .eng_rx_addr_i(rxa), .eng_own_match_i(own), .eng_header_sent_i(ev[2]),
    .eng_end_addr_i(ev[3]), .eng_ack_fail_i(ev[4]), .eng_arb_lost_i(ev[5]), .eng_bus_err_i(ev[6]),
    .eng_rx_data_i(rxd), .eng_scl_low_i(scl_low), .eng_sda_low_i(sda_low),
    .irq_bus_o(irq_bus), .irq_data_o(irq_data)
  );
  icsc_far_model u_icsc_far_model (
    .clk_i(clk), .start_req_i(start_o), .stop_req_i(stop_o), .ext_i(ext), .slow_i(slow),
    .scl_oe_i(scl_oe), .sda_oe_i(sda_oe), .start_done_o(sdone), .stop_done_o(pdone),
    .scl_o(scl), .sda_o(sda)
  );
  // ************************************************
  // helpers
  // ************************************************
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  // address acknowledged unless 01h: own match, or general call while enabled
  function automatic logic gc_hit(input logic [7:0] a, input logic o, input logic gce);
    return (a != 8'h01) & (o | (gce & (a == 8'h00)));
  endfunction : gc_hit
  task automatic print_verdict();
    if (fails == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : print_verdict
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task automatic wrr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask : wrr
  task automatic rdc(input logic [4:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    cmp(rdata, exp);
  endtask : rdc
  // one-cycle engine event with the levels that qualify it
  task automatic pl(input int i, input logic [7:0] a, input logic o, input logic t);
    @(posedge clk);
    ev[i] <= 1'b1;
    rxa <= a;
    rxd <= a;
    own <= o;
    btx <= t;
    @(posedge clk);
    ev <= 7'h00;
    #1;
  endtask : pl
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle
  task automatic wait_eng();
    for (int k = 0; k < 400; k++) begin
      @(posedge clk);
      if (start_o === 1'b0 && stop_o === 1'b0) begin
        return;
      end
    end
    fails++;
    print_verdict();
  endtask : wait_eng
  task automatic ext_cond(input logic [1:0] v);
    @(posedge clk);
    ext <= v;
    @(posedge clk);
    ext <= 2'b00;
    settle(24);
  endtask : ext_cond
  // ************************************************
  // main sequence
  // ************************************************
  initial begin
    logic [31:0] r;
    logic [7:0] la;
    logic lo;
    logic hit;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    rdc(5'h00, 8'h00);
    rdc(5'h04, 8'h00);
    rdc(5'h0c, 8'h00);
    wrr(5'h00, 8'h3f);
    rdc(5'h00, 8'h20);
    wrr(5'h00, 8'hf5);
    rdc(5'h00, 8'h35);
    cmp({7'h00, ack_en}, 8'h01);
    // general call corners 00h and 01h, then random addresses
    for (int i = 0; i < 12; i++) begin
      r = xs();
      la = (i < 2) ? 8'(i) : r[7:0];
      lo = (i >= 2) && r[8];
      hit = gc_hit(la, lo, 1'b1);
      pl(1, la, lo, 1'b0);
      cmp({7'h00, addr_ack}, {7'h00, hit});
      settle(1);
      cmp({6'h00, irq_data, scl_oe}, {6'h00, hit, hit});
      rdc(5'h04, hit ? 8'h84 : 8'h00);
    end
    rdc(5'h04, 8'h00);
    // slave receive, then release lines with stop while byte finished
    r = xs();
    pl(0, r[7:0], 1'b0, 1'b0);
    scl_low <= 1'b1;
    rdc(5'h04, 8'h88);
    cmp({7'h00, scl_oe}, 8'h01);
    wrr(5'h00, 8'h37);
    settle(3);
    cmp({5'h00, stop_o, scl_oe, sda_oe}, 8'h00);
    rdc(5'h00, 8'h37);
    scl_low <= 1'b0;
    wrr(5'h00, 8'h35);
    rdc(5'h18, r[7:0]);
    rdc(5'h04, 8'h00);
    // master start with a prompt far side
    wrr(5'h00, 8'h3d);
    settle(2);
    cmp({7'h00, start_o}, 8'h01);
    wait_eng();
    settle(2);
    rdc(5'h04, 8'h93);
    rdc(5'h00, 8'h35);
    cmp({7'h00, irq_bus}, 8'h01);
    r = xs();
    wrr(5'h18, r[7:0]);
    cmp({7'h00, tx_load}, 8'h01);
    cmp(tx_data, r[7:0]);
    rdc(5'h04, 8'h12);
    pl(0, 8'h00, 1'b0, 1'b1);
    rdc(5'h04, 8'hba);
    wrr(5'h18, r[15:8]);
    rdc(5'h04, 8'h12);
    pl(0, r[23:16], 1'b0, 1'b0);
    rdc(5'h04, 8'h9a);
    rdc(5'h18, r[23:16]);
    rdc(5'h04, 8'h12);
    // master stop with a slow far side
    slow <= 1'b1;
    wrr(5'h00, 8'h37);
    settle(3);
    cmp({7'h00, stop_o}, 8'h01);
    wait_eng();
    settle(6);
    rdc(5'h00, 8'h35);
    rdc(5'h04, 8'h80);
    rdc(5'h08, 8'h08);
    rdc(5'h04, 8'h00);
    // error events, with and without interrupt enable
    for (int j = 0; j < 2; j++) begin
      wrr(5'h00, (j == 0) ? 8'h35 : 8'h34);
      for (int i = 4; i < 7; i++) begin
        pl(i, 8'h00, 1'b0, 1'b0);
        settle(1);
        cmp({7'h00, irq_bus}, (j == 0) ? 8'h01 : 8'h00);
        rdc(5'h04, 8'h80);
        rdc(5'h08, (i == 4) ? 8'h10 : (i == 5) ? 8'h04 : 8'h02);
        rdc(5'h04, 8'h00);
      end
    end
    wrr(5'h00, 8'h35);
    pl(2, 8'h00, 1'b0, 1'b0);
    rdc(5'h04, 8'hc0);
    rdc(5'h08, 8'h00);
    wrr(5'h18, 8'h5a);
    rdc(5'h04, 8'h00);
    pl(3, 8'h00, 1'b0, 1'b0);
    settle(1);
    cmp({6'h00, scl_oe, irq_bus}, 8'h03);
    rdc(5'h08, 8'h20);
    wrr(5'h00, 8'h35);
    rdc(5'h04, 8'h00);
    // disable with flags pending and the engine pulling both lines
    pl(0, 8'h00, 1'b0, 1'b1);
    pl(2, 8'h00, 1'b0, 1'b0);
    scl_low <= 1'b1;
    sda_low <= 1'b1;
    settle(2);
    cmp({4'h0, scl_o, sda_o, scl_oe, sda_oe}, 8'h03);
    wrr(5'h00, 8'h02);
    settle(2);
    cmp({4'h0, scl_oe, sda_oe, ack_en, irq_data}, 8'h00);
    rdc(5'h00, 8'h02);
    rdc(5'h04, 8'h00);
    scl_low <= 1'b0;
    sda_low <= 1'b0;
    wrr(5'h00, 8'h00);
    ext_cond(2'b01);
    rdc(5'h04, 8'h10);
    ext_cond(2'b10);
    rdc(5'h04, 8'h00);
    print_verdict();
  end
endmodule : icsc_core_bench

//--- verif/icsc_far_model.sv
// icsc_far_model.sv: far side of the core, the bus lines and the engine's done answers
// assumes: runs on the bench clock; both lines pulled up and wired-and with the core
`timescale 1ns/1ps
module icsc_far_model (
  // clock
  input wire logic clk_i,
  // requests
  input wire logic start_req_i,
  input wire logic stop_req_i,
  input wire logic [1:0] ext_i,
  input wire logic slow_i,
  input wire logic scl_oe_i,
  input wire logic sda_oe_i,
  // answers
  output logic start_done_o,
  output logic stop_done_o,
  output logic scl_o,
  output logic sda_o
);
  logic scl_d;
  logic sda_d;
  // ************************************************
  // wired lines
  // ************************************************
  // a released line floats up to the pull-up level
  assign scl_o = !(scl_d | scl_oe_i);
  assign sda_o = !(sda_d | sda_oe_i);
  // ************************************************
  // conditions, half a 400 ns link period is 4 clocks
  // ************************************************
  // data is set before clock rises and changes with clock high only for the wanted condition
  task automatic cond(input logic st);
    sda_d <= !st;
    repeat (4) @(posedge clk_i);
    scl_d <= 1'b0;
    repeat (4) @(posedge clk_i);
    sda_d <= st;
    repeat (4) @(posedge clk_i);
    scl_d <= st;
  endtask : cond
  initial begin
    scl_d = 1'b0;
    sda_d = 1'b0;
    start_done_o = 1'b0;
    stop_done_o = 1'b0;
    forever begin
      @(posedge clk_i);
      if (start_req_i || stop_req_i) begin
        repeat (slow_i ? 40 : 2) @(posedge clk_i);
        cond(start_req_i);
        start_done_o <= start_req_i;
        stop_done_o <= !start_req_i;
        @(posedge clk_i);
        start_done_o <= 1'b0;
        stop_done_o <= 1'b0;
      end else if (ext_i != 2'b00) begin
        cond(ext_i[0]);
      end
    end
  end
endmodule : icsc_far_model
